// [hw/bds_pkg.sv]
// bds_pkg: constants and carriers for the buffer memory sequencer
package bds_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ROW_W = 9;
    localparam int COL_W = 9;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;
    localparam int REF_W = 10;

    // ------------------------------------------------------------
    // clock period in ns, intervals all in system clock periods
    // ------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam logic [CNT_W-1:0] T_PRE = 4'h4;
    localparam logic [CNT_W-1:0] T_RCD = 4'h2;
    localparam logic [CNT_W-1:0] T_CAS_FIRST = 4'h5;
    localparam logic [CNT_W-1:0] T_CAS_PAGE = 4'h3;
    localparam logic [CNT_W-1:0] T_RHOLD = 4'h4;
    localparam logic [CNT_W-1:0] T_WE_HOLD = 4'h1;
    localparam logic [CNT_W-1:0] T_REF_RP = 4'h4;
    localparam logic [CNT_W-1:0] T_REF_CSR = 4'h2;
    localparam logic [CNT_W-1:0] T_REF_CHR = 4'h6;
    localparam logic [CNT_W-1:0] T_SRAM_CYC = 4'h6;
    localparam logic [CNT_W-1:0] T_SRAM_AS = 4'h1;
    localparam logic [CNT_W-1:0] T_SRAM_WP = 4'h2;
    localparam logic [CNT_W-1:0] T_SRAM_RD = 4'h4;

    // ------------------------------------------------------------
    // refresh spacing limits and safety margin
    // ------------------------------------------------------------
    localparam logic [REF_W-1:0] REF_LIM_FAST = 10'h190;
    localparam logic [REF_W-1:0] REF_LIM_SLOW = 10'h320;
    localparam logic [REF_W-1:0] REF_MARGIN = 10'h028;
    localparam int CFG_REF_BIT = 3;

    // ------------------------------------------------------------
    // reset values of the memory pins
    // ------------------------------------------------------------
    localparam logic RST_STROBE_N = 1'b1;

    typedef struct packed {
        logic write;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DATA_W-1:0] wdata;
    } bds_req_t;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [ROW_W-1:0] addr;
    } bds_dram_pins_t;

endpackage

// [hw/bds_sequencer.sv]
// bds_sequencer: buffer dram / sram access and refresh sequencer
`timescale 1ns/1ps
// Notes on behaviour
// RULE1 - single access cycle at least 10 clocks
// RULE2 - page column accesses at least 4 clocks apart
// RULE3 - memory data valid 3T-10 after column strobe
// RULE4 - memory data valid 7T-10 after row strobe
// RULE5 - row strobe low 4T after last precharge
// RULE6 - column strobe high one clock between accesses
// RULE7 - column strobe falls 2T after row strobe
// RULE8 - column address switches 1T after row strobe
// RULE9 - row address 3T before, 1T after row strobe
// RULE10 - column address set-up 1T, held 3T/5T
// RULE11 - column address 3T before row strobe rises
// RULE12 - column strobe high 3T before row falls
// RULE13 - read write strobe inactive around strobes
// RULE14 - write strobe low at least 10 clocks
// RULE15 - write strobe leads column 9T, row 8T
// RULE16 - write data set-up 1T, held 3T/7T
// RULE17 - refresh column strobe leads 2T, holds 6T
// RULE18 - one clock after row precharge before column
// RULE19 - memory may release data at column rise
// RULE20 - refresh within 400 or 800 clocks
// RULE21 - every interval counted in system clocks
// RULE22 - sram cycles 6 clocks, pulse 2, set-up 1
module bds_sequencer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] memory_config_setting,
    input wire logic sram_sel,
    input wire logic req_valid,
    output logic req_ready,
    input wire bds_pkg::bds_req_t req,
    output logic [bds_pkg::DATA_W-1:0] rd_data,
    output logic rd_valid,
    output bds_pkg::bds_dram_pins_t dram,
    output logic [bds_pkg::ROW_W+bds_pkg::COL_W-1:0] sram_addr,
    output logic sram_ce_n,
    output logic sram_oe_n,
    output logic [bds_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [bds_pkg::DATA_W-1:0] dq_in
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_PRE = 4'h1,
        ST_RCD = 4'h3,
        ST_CAS = 4'h2,
        ST_CPRE = 4'h6,
        ST_RHOLD = 4'h7,
        ST_REF_PRE = 4'h5,
        ST_REF_CAS = 4'h4,
        ST_REF_RAS = 4'hc,
        ST_SRAM = 4'hd
    } bds_state_t;

    bds_state_t state_r;
    logic [bds_pkg::CNT_W-1:0] cnt_r;
    logic [bds_pkg::ROW_W-1:0] row_r;
    logic [bds_pkg::COL_W-1:0] col_r;
    logic write_r;
    logic [bds_pkg::REF_W-1:0] ref_cnt_r;
    logic [bds_pkg::REF_W-1:0] ref_lim;
    logic ref_due;
    logic page_hit;
    logic cap0_r;
    logic cap1_r;
    logic [bds_pkg::DATA_W-1:0] dq_s1_r;
    logic [bds_pkg::DATA_W-1:0] dq_s2_r;

    // ------------------------------------------------------------
    // refresh timer
    // ------------------------------------------------------------
    // margin covers the longest access plus the refresh lead-in
    assign ref_lim = memory_config_setting[bds_pkg::CFG_REF_BIT] ?
        bds_pkg::REF_LIM_SLOW : bds_pkg::REF_LIM_FAST; // [RULE20]
    assign ref_due = !sram_sel && (ref_cnt_r >= ref_lim - bds_pkg::REF_MARGIN); // [RULE20]

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ref_cnt_r <= '0;
        end
        else if (state_r == ST_REF_CAS && cnt_r == '0)
        begin
            ref_cnt_r <= '0; // [RULE20]
        end
        else if (!ref_due || ref_cnt_r != ref_lim)
        begin
            ref_cnt_r <= ref_cnt_r + 10'h001; // [RULE21]
        end
    end

    // ------------------------------------------------------------
    // request acceptance
    // ------------------------------------------------------------
    // page continuation only for reads: a write needs a long strobe
    assign page_hit = req_valid && !req.write && !write_r && !ref_due &&
        req.row == row_r;

    always_comb
    begin
        req_ready = 1'b0;
        if (state_r == ST_IDLE)
        begin
            req_ready = !ref_due;
        end
        else if (state_r == ST_CAS && cnt_r == '0)
        begin
            req_ready = page_hit; // [RULE2]
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            row_r <= '0;
            col_r <= '0;
            write_r <= 1'b0;
            dram.ras_n <= bds_pkg::RST_STROBE_N;
            dram.cas_n <= bds_pkg::RST_STROBE_N;
            dram.we_n <= bds_pkg::RST_STROBE_N;
            dram.addr <= '0;
            sram_addr <= '0;
            sram_ce_n <= bds_pkg::RST_STROBE_N;
            sram_oe_n <= bds_pkg::RST_STROBE_N;
            dq_out <= '0;
            dq_oe <= 1'b0;
            cap0_r <= 1'b0;
        end
        else
        begin
            cap0_r <= 1'b0;
            if (cnt_r != '0)
            begin
                cnt_r <= cnt_r - 4'h1; // [RULE21]
            end
            unique case (state_r)
                ST_IDLE:
                begin
                    if (ref_due)
                    begin
                        state_r <= ST_REF_PRE;
                        cnt_r <= bds_pkg::T_REF_RP - 4'h1; // [RULE18]
                    end
                    else if (req_valid && sram_sel)
                    begin
                        state_r <= ST_SRAM;
                        cnt_r <= bds_pkg::T_SRAM_CYC - 4'h1; // [RULE22]
                        write_r <= req.write;
                        sram_addr <= {req.row, req.col}; // [RULE22]
                        sram_ce_n <= 1'b0;
                        dq_out <= req.wdata;
                        dq_oe <= req.write;
                    end
                    else if (req_valid)
                    begin
                        state_r <= ST_PRE;
                        cnt_r <= bds_pkg::T_PRE - 4'h1; // [RULE9]
                        row_r <= req.row;
                        col_r <= req.col;
                        write_r <= req.write;
                        dram.addr <= req.row; // [RULE9]
                        dram.we_n <= !req.write; // [RULE15] [RULE13]
                        dq_out <= req.wdata; // [RULE16]
                        dq_oe <= req.write;
                    end
                end
                ST_PRE:
                begin
                    if (cnt_r == '0)
                    begin
                        state_r <= ST_RCD;
                        cnt_r <= bds_pkg::T_RCD - 4'h1;
                        dram.ras_n <= 1'b0;
                    end
                end
                ST_RCD:
                begin
                    if (cnt_r == bds_pkg::T_RCD - 4'h1)
                    begin
                        dram.addr <= col_r; // [RULE8] [RULE10]
                    end
                    if (cnt_r == '0)
                    begin
                        state_r <= ST_CAS;
                        // long first strobe waits out the row access time
                        cnt_r <= bds_pkg::T_CAS_FIRST - 4'h1; // [RULE7] [RULE4]
                        dram.cas_n <= 1'b0;
                    end
                end
                ST_CAS:
                begin
                    if (cnt_r == '0)
                    begin
                        dram.cas_n <= 1'b1;
                        cap0_r <= !write_r; // [RULE3] [RULE19]
                        if (page_hit)
                        begin
                            state_r <= ST_CPRE;
                            col_r <= req.col;
                            dram.addr <= req.col; // [RULE10]
                        end
                        else
                        begin
                            state_r <= ST_RHOLD;
                            cnt_r <= bds_pkg::T_RHOLD - 4'h1; // [RULE5] [RULE11]
                        end
                    end
                end
                ST_CPRE:
                begin
                    state_r <= ST_CAS;
                    cnt_r <= bds_pkg::T_CAS_PAGE - 4'h1; // [RULE2] [RULE6]
                    dram.cas_n <= 1'b0;
                end
                ST_RHOLD:
                begin
                    if (cnt_r == bds_pkg::T_RHOLD - bds_pkg::T_WE_HOLD)
                    begin
                        dram.we_n <= 1'b1; // [RULE14] [RULE15]
                    end
                    if (cnt_r == '0)
                    begin
                        // row closes; pre-charge of the next access restores
                        state_r <= ST_IDLE;
                        dram.ras_n <= 1'b1; // [RULE1] [RULE12]
                        dram.we_n <= 1'b1; // [RULE13]
                        dq_oe <= 1'b0; // [RULE16]
                    end
                end
                ST_REF_PRE:
                begin
                    if (cnt_r == '0)
                    begin
                        state_r <= ST_REF_CAS;
                        cnt_r <= bds_pkg::T_REF_CSR - 4'h1;
                        dram.cas_n <= 1'b0; // [RULE17] [RULE18]
                    end
                end
                ST_REF_CAS:
                begin
                    if (cnt_r == '0)
                    begin
                        state_r <= ST_REF_RAS;
                        cnt_r <= bds_pkg::T_REF_CHR - 4'h1; // [RULE17]
                        dram.ras_n <= 1'b0;
                    end
                end
                ST_REF_RAS:
                begin
                    if (cnt_r == '0)
                    begin
                        state_r <= ST_IDLE;
                        dram.ras_n <= 1'b1;
                        dram.cas_n <= 1'b1;
                    end
                end
                ST_SRAM:
                begin
                    if (cnt_r == bds_pkg::T_SRAM_CYC - bds_pkg::T_SRAM_AS - 4'h1)
                    begin
                        dram.we_n <= !write_r; // [RULE22]
                        sram_oe_n <= write_r;
                    end
                    if (cnt_r == bds_pkg::T_SRAM_CYC - bds_pkg::T_SRAM_AS
                        - bds_pkg::T_SRAM_WP - 4'h1)
                    begin
                        dram.we_n <= 1'b1; // [RULE22]
                    end
                    if (cnt_r == bds_pkg::T_SRAM_CYC - bds_pkg::T_SRAM_RD - 4'h1)
                    begin
                        sram_oe_n <= 1'b1;
                        cap0_r <= !write_r;
                    end
                    if (cnt_r == '0)
                    begin
                        state_r <= ST_IDLE;
                        sram_ce_n <= 1'b1;
                        dq_oe <= 1'b0;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // read data capture
    // ------------------------------------------------------------
    // pin data is synchronised; the flag follows the same two stages
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dq_s1_r <= '0;
            dq_s2_r <= '0;
        end
        else
        begin
            dq_s1_r <= dq_in;
            dq_s2_r <= dq_s1_r;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cap1_r <= 1'b0;
            rd_data <= '0;
            rd_valid <= 1'b0;
        end
        else
        begin
            cap1_r <= cap0_r;
            rd_valid <= cap1_r;
            if (cap1_r)
            begin
                rd_data <= dq_s2_r; // [RULE19]
            end
        end
    end

endmodule

// [testbench/bds_seq_assertions.sv]
// concurrent checks on the buffer memory sequencer ports
`timescale 1ns/1ps
module bds_seq_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] memory_config_setting,
    input wire logic sram_sel,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire bds_pkg::bds_req_t req,
    input wire logic [bds_pkg::DATA_W-1:0] rd_data,
    input wire logic rd_valid,
    input wire bds_pkg::bds_dram_pins_t dram,
    input wire logic [bds_pkg::ROW_W+bds_pkg::COL_W-1:0] sram_addr,
    input wire logic sram_ce_n,
    input wire logic sram_oe_n,
    input wire logic [bds_pkg::DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    input wire logic [bds_pkg::DATA_W-1:0] dq_in
);
    logic [3:0] cas_gap_r;
    logic [3:0] ras_gap_r;
    logic [9:0] ref_gap_r;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // gap counters, saturating so long idles cannot wrap
    // ------------------------------------------------------------
    // reset reads as a long gap: no strobe has fallen yet
    always_ff @(posedge mclk)
    begin
        if (rst)
            cas_gap_r <= 4'hf;
        else if ($fell(dram.cas_n))
            cas_gap_r <= 4'h1;
        else if (cas_gap_r != 4'hf)
            cas_gap_r <= cas_gap_r + 4'h1;
    end
    always_ff @(posedge mclk)
    begin
        if (rst)
            ras_gap_r <= 4'hf;
        else if ($fell(dram.ras_n))
            ras_gap_r <= 4'h1;
        else if (ras_gap_r != 4'hf)
            ras_gap_r <= ras_gap_r + 4'h1;
    end
    always_ff @(posedge mclk)
    begin
        if (rst || sram_sel || ($fell(dram.ras_n) && !dram.cas_n))
            ref_gap_r <= 10'h000;
        else if (ref_gap_r != 10'h3ff)
            ref_gap_r <= ref_gap_r + 10'h001;
    end
    // ------------------------------------------------------------
    // strobe timing
    // ------------------------------------------------------------
    page_gap_a: assert property ($fell(dram.cas_n) && !dram.ras_n |-> cas_gap_r >= 4'h4)
        else $error("column strobes too close");
    row_cycle_a: assert property ($fell(dram.ras_n) |-> ras_gap_r >= 4'ha)
        else $error("row cycle too short");
    ras_cas_a: assert property ($fell(dram.cas_n) && !dram.ras_n |-> !$past(dram.ras_n, 2))
        else $error("column strobe too soon after row strobe");
    cas_lead_a: assert property ($fell(dram.ras_n) && dram.cas_n |->
        $past(dram.cas_n, 1) && $past(dram.cas_n, 2) && $past(dram.cas_n, 3))
        else $error("column strobe not high long enough before row strobe");
    refresh_cas_a: assert property ($fell(dram.ras_n) && !dram.cas_n |->
        !$past(dram.cas_n, 2) ##0 (!dram.cas_n)[*6])
        else $error("refresh column strobe timing");
    row_addr_a: assert property ($fell(dram.ras_n) && dram.cas_n |->
        $stable(dram.addr) && dram.addr == $past(dram.addr, 3))
        else $error("row address not held");
    col_addr_a: assert property ($fell(dram.cas_n) && !dram.ras_n |->
        $stable(dram.addr) ##1 $stable(dram.addr)[*2])
        else $error("column address not held");
    write_pulse_a: assert property ($fell(dram.we_n) && !sram_sel |->
        (!dram.we_n)[*8] ##1 (!dram.we_n)[*2])
        else $error("write strobe too short");
    sram_pulse_a: assert property ($fell(dram.we_n) && sram_sel |->
        (!dram.we_n)[*2] ##1 dram.we_n)
        else $error("sram write pulse wrong");
    write_data_a: assert property ($fell(dram.cas_n) && dq_oe |->
        $stable(dq_out) ##1 ($stable(dq_out) && dq_oe)[*3])
        else $error("write data not held");
    ref_spacing_a: assert property (!sram_sel |->
        ref_gap_r <= (memory_config_setting[3] ? 10'h320 : 10'h190))
        else $error("refresh overdue");
    read_answer_a: assert property ($rose(dram.cas_n) && !dram.ras_n && dram.we_n |-> ##2 rd_valid)
        else $error("read answer late");
    cover property ($fell(dram.ras_n) && !dram.cas_n);
    cover property ($fell(dram.cas_n) && !dram.ras_n && cas_gap_r == 4'h4);
    cover property ($fell(dram.we_n) && sram_sel);
endmodule

bind bds_sequencer bds_seq_assertions chk_u (.mclk, .rst, .memory_config_setting, .sram_sel,
    .req_valid, .req_ready, .req, .rd_data, .rd_valid, .dram, .sram_addr, .sram_ce_n,
    .sram_oe_n, .dq_out, .dq_oe, .dq_in);

// [testbench/bds_dram_model.sv]
// behavioural buffer memory on the far side of the sequencer
`timescale 1ns/1ps
module bds_dram_model (
    input wire logic mclk,
    input wire bds_pkg::bds_dram_pins_t dram,
    input wire logic [17:0] sram_addr,
    input wire logic sram_ce_n,
    input wire logic sram_oe_n,
    input wire logic dq_oe,
    input wire logic [7:0] dq_out,
    input wire logic slow,
    output logic [7:0] dq_in
);
    logic [7:0] mem [0:262143];
    logic [8:0] row_r = 9'h000;
    logic [17:0] adr_r = 18'h00000;
    logic ras_q = 1'b1;
    logic cas_q = 1'b1;
    logic [1:0] wait_r = 2'h0;
    initial dq_in = 8'h00;
    always @(posedge mclk)
    begin
        ras_q <= dram.ras_n;
        cas_q <= dram.cas_n;
        if (ras_q && !dram.ras_n && dram.cas_n)
            row_r <= dram.addr;
        if (!sram_ce_n && !dram.we_n && dq_oe)
            mem[sram_addr] <= dq_out;
        if (cas_q && !dram.cas_n && !dram.ras_n)
        begin
            adr_r <= {row_r, dram.addr};
            wait_r <= slow ? 2'h2 : 2'h1;
            if (!dram.we_n && dq_oe)
                mem[{row_r, dram.addr}] <= dq_out;
        end
        else if (!dram.cas_n && !dram.ras_n && dram.we_n && wait_r > 2'h1)
            wait_r <= wait_r - 2'h1;
        else if (!dram.cas_n && !dram.ras_n && dram.we_n)
            dq_in <= mem[adr_r];
        else if (!sram_ce_n && !sram_oe_n)
            dq_in <= mem[sram_addr];
        else
            dq_in <= ~dq_in; // released bus, never a stale value
    end
endmodule

// [testbench/test_buffer_dram_timing_sequencer.sv]
// self-checking bench for the buffer memory sequencer
`timescale 1ns/1ps
module test_buffer_dram_timing_sequencer;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] memory_config_setting = 8'h00;
    logic sram_sel = 1'b0;
    logic req_valid = 1'b0;
    logic req_ready;
    bds_pkg::bds_req_t req = '0;
    logic [7:0] rd_data;
    logic rd_valid;
    bds_pkg::bds_dram_pins_t dram;
    logic [17:0] sram_addr;
    logic sram_ce_n;
    logic sram_oe_n;
    logic [7:0] dq_out;
    logic dq_oe;
    logic [7:0] dq_in;
    logic slow = 1'b0;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    bds_sequencer dut_u (.mclk, .rst, .memory_config_setting, .sram_sel, .req_valid, .req_ready,
        .req, .rd_data, .rd_valid, .dram, .sram_addr, .sram_ce_n, .sram_oe_n, .dq_out, .dq_oe,
        .dq_in);
    bds_dram_model mem_u (.mclk, .dram, .sram_addr, .sram_ce_n, .sram_oe_n, .dq_oe, .dq_out,
        .slow, .dq_in);
    initial
    begin
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // valid stays up on return so a following send is back-to-back
    task automatic send(input logic w, input logic [8:0] r, input logic [8:0] c,
        input logic [7:0] d);
        int n;
        n = 0;
        req_valid <= 1'b1;
        req <= '{write: w, row: r, col: c, wdata: d};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (req_ready !== 1'b1 && n < 60);
        if (n >= 60)
            fails++;
    endtask
    task automatic get(input string what, input logic [7:0] exp);
        int n;
        n = 0;
        while (rd_valid !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        chk("read answer in time", 8'h01, {7'h00, rd_valid === 1'b1});
        chk(what, exp, rd_data);
    endtask
    task automatic watch(input int cycles, output int nr, output int mg);
        int g;
        logic rq;
        g = 0;
        nr = 0;
        mg = 0;
        rq = 1'b1;
        repeat (cycles)
        begin
            @(posedge mclk);
            g++;
            if (rq && !dram.ras_n && !dram.cas_n)
            begin
                nr++;
                g = 0;
            end
            if (nr > 0 && g > mg)
                mg = g;
            rq = dram.ras_n;
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_access;
        send(1'b1, 9'h000, 9'h001, 8'h5a);
        req_valid <= 1'b0;
        @(posedge mclk);
        chk("ready while busy", 8'h00, {7'h00, req_ready});
        send(1'b1, 9'h1ff, 9'h1ff, 8'ha5);
        send(1'b0, 9'h000, 9'h001, 8'h00);
        req_valid <= 1'b0;
        get("read fast", 8'h5a);
        slow <= 1'b1;
        send(1'b0, 9'h1ff, 9'h1ff, 8'h00);
        req_valid <= 1'b0;
        get("read slow", 8'ha5);
        // slow answers would miss a page access, whose strobe is only 3 clocks
        slow <= 1'b0;
    endtask
    task automatic s_page;
        int t0;
        send(1'b1, 9'h0a0, 9'h010, 8'h11);
        send(1'b1, 9'h0a0, 9'h011, 8'h22);
        send(1'b0, 9'h0a0, 9'h010, 8'h00);
        send(1'b0, 9'h0a0, 9'h011, 8'h00);
        req_valid <= 1'b0;
        get("page first", 8'h11);
        t0 = cyc;
        @(posedge mclk);
        get("page second", 8'h22);
        chk("page spacing", 8'h04, 8'(cyc - t0));
    endtask
    task automatic s_refresh;
        int nr;
        int mg;
        watch(900, nr, mg);
        chk("refresh count short", 8'h01, {7'h00, nr >= 2});
        chk("refresh gap short", 8'h01, {7'h00, mg <= 400});
        memory_config_setting <= 8'h08;
        watch(1700, nr, mg);
        chk("refresh count long", 8'h01, {7'h00, nr >= 2});
        chk("refresh gap long", 8'h01, {7'h00, mg <= 800});
    endtask
    task automatic s_sram;
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        sram_sel <= 1'b1;
        @(posedge mclk);
        send(1'b1, 9'h003, 9'h0c4, 8'h3c);
        send(1'b0, 9'h003, 9'h0c4, 8'h00);
        req_valid <= 1'b0;
        get("sram read", 8'h3c);
    endtask
    initial
    begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        s_access();
        s_page();
        s_refresh();
        s_sram();
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        fails++;
        complete_run();
    end
endmodule
